// >>> common/orc_pkg.sv
// constants for the overrange and sysref calibration register bank
// assumes byte-wide registers at their own addresses on a plain register port
package orc_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int SAMPLE_W = 12;
   localparam int LANES = 12;
   localparam int LEVEL_W = 8;
   localparam int PULSE_CNT_W = 11;
   localparam int CAL_CNT_W = 18;

   // register addresses
   localparam logic [ADDR_W-1:0] OFS_CHAN_SHUTDOWN = 12'h209;
   localparam logic [ADDR_W-1:0] OFS_LEVEL_ZERO = 12'h211;
   localparam logic [ADDR_W-1:0] OFS_LEVEL_ONE = 12'h212;
   localparam logic [ADDR_W-1:0] OFS_OUTPUT_CONFIG = 12'h213;
   localparam logic [ADDR_W-1:0] OFS_REVISION = 12'h297;
   localparam logic [ADDR_W-1:0] OFS_CAL_START = 12'h2b0;
   localparam logic [ADDR_W-1:0] OFS_CAL_SETUP = 12'h2b1;
   localparam logic [ADDR_W-1:0] OFS_CAL_STAT_0 = 12'h2b2;
   localparam logic [ADDR_W-1:0] OFS_CAL_STAT_1 = 12'h2b3;
   localparam logic [ADDR_W-1:0] OFS_CAL_STAT_2 = 12'h2b4;

   // reset values
   localparam logic [DATA_W-1:0] RST_CHAN_SHUTDOWN = 8'h00;
   localparam logic [DATA_W-1:0] RST_LEVEL_ZERO = 8'hf2;
   localparam logic [DATA_W-1:0] RST_LEVEL_ONE = 8'hab;
   localparam logic [DATA_W-1:0] RST_OUTPUT_CONFIG = 8'h07;
   localparam logic [DATA_W-1:0] RST_CAL_START = 8'h00;
   localparam logic [DATA_W-1:0] RST_CAL_SETUP = 8'h05;

   // writable bits; the rest read as zero
   localparam logic [DATA_W-1:0] WMASK_CHAN_SHUTDOWN = 8'h03;
   localparam logic [DATA_W-1:0] WMASK_OUTPUT_CONFIG = 8'h0f;
   localparam logic [DATA_W-1:0] WMASK_CAL_START = 8'h01;
   localparam logic [DATA_W-1:0] WMASK_CAL_SETUP = 8'h0f;

   // field positions
   localparam int SHUT_A_BIT = 0;
   localparam int SHUT_B_BIT = 1;
   localparam int PINS_EN_BIT = 3;
   localparam int PULSE_EXP_LSB = 0;
   localparam int PULSE_EXP_W = 3;
   localparam int CAL_START_BIT = 0;
   localparam int CAL_AVG_LSB = 2;
   localparam int CAL_ACC_LSB = 0;
   localparam int CAL_FIELD_W = 2;
   localparam int REV_W = 5;
   localparam int CAL_DONE_BIT = 1;

   // timing counts in sampling-clock cycles
   localparam int PULSE_BASE_CYCLES = 8;
   localparam int CAL_ACCUMS = 256;
   localparam int CAL_STEPS = 19;
   localparam int CAL_PHASES = 4;
   localparam int CAL_UNIT_CYCLES = CAL_ACCUMS * CAL_STEPS * CAL_PHASES;
   localparam int CAL_CODE_BIAS = 2;

   typedef enum logic [1:0] {
      CAL_IDLE,
      CAL_RUN,
      CAL_FINISHED
   } orc_cal_state_type;

endpackage : orc_pkg

// >>> dv/testbench.sv
// self-checking bench for the overrange and sysref calibration register bank
// assumes orc_pkg is compiled first; the bench drives every port of orc_regs itself
`timescale 1ns/10ps
module testbench;
   localparam int UNIT = 4;
   // arbitrary neutral revision code
   localparam logic [orc_pkg::REV_W-1:0] REV = 5'h0a;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic ce_i = 1'b1;
   logic [orc_pkg::ADDR_W-1:0] addr_i = 12'h000;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [11:0] sa = 12'h000;
   logic [11:0] sb = 12'h000;
   logic [7:0] rdata_o;
   logic sh_a, sh_b, f_a0, f_a1, f_b0, f_b1, p_a0, p_a1, p_b0, p_b1, auto_sel, busy, done;
   logic [11:0] lanes_a, lanes_b;
   logic [1:0] stb_en, clk_en;
   logic [7:0] t0_ff, t1_ff, cfg_ff, shut_ff, st_ff;
   logic [3:0] flag_x, pin_x;
   logic [10:0] cnt [4];
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;

   orc_regs #(.CAL_UNIT_CYCLES(UNIT), .REVISION_CODE(REV)) DUT (.clk_i(clk_i),
      .arst_n_i(arst_n_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .chan_a_sample_i(sa), .chan_b_sample_i(sb),
      .shutdown_chan_a_o(sh_a), .shutdown_chan_b_o(sh_b), .chan_a_lanes_enable_o(lanes_a),
      .chan_b_lanes_enable_o(lanes_b), .lane_frame_strobe_enable_o(stb_en),
      .lane_output_clock_enable_o(clk_en), .chan_a_level0_flag_o(f_a0),
      .chan_a_level1_flag_o(f_a1), .chan_b_level0_flag_o(f_b0), .chan_b_level1_flag_o(f_b1),
      .chan_a_level0_pin_o(p_a0), .chan_a_level1_pin_o(p_a1), .chan_b_level0_pin_o(p_b0),
      .chan_b_level1_pin_o(p_b1), .aperture_auto_select_o(auto_sel),
      .sysref_cal_busy_o(busy), .sysref_cal_complete_o(done));

   always #20 clk_i = ~clk_i;

   function automatic logic [12:0] mag(input logic [11:0] s);
      return s[11] ? 13'h1000 - {1'b0, s} : {1'b0, s};
   endfunction : mag

   function automatic logic hit(input logic [11:0] s, input logic [7:0] t, input logic off);
      return !off && (mag(s) >= {2'b00, t, 3'b000});
   endfunction : hit

   // reference copy of the registers except calibration setup, and of the four stretchers
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         t0_ff <= 8'hf2;
         t1_ff <= 8'hab;
         cfg_ff <= 8'h07;
         shut_ff <= 8'h00;
         st_ff <= 8'h00;
         flag_x <= 4'h0;
         pin_x <= 4'h0;
         for (int i = 0; i < 4; i++) cnt[i] <= 11'h000;
      end else begin
         if (wr_i) begin
            case (addr_i)
               orc_pkg::OFS_LEVEL_ZERO: t0_ff <= wdata_i;
               orc_pkg::OFS_LEVEL_ONE: t1_ff <= wdata_i;
               orc_pkg::OFS_OUTPUT_CONFIG: cfg_ff <= wdata_i & 8'h0f;
               orc_pkg::OFS_CHAN_SHUTDOWN: shut_ff <= wdata_i & 8'h03;
               orc_pkg::OFS_CAL_START: st_ff <= wdata_i & 8'h01;
               default: ;
            endcase
         end
         for (int i = 0; i < 4; i++) begin
            logic h;
            h = hit(i < 2 ? sa : sb, i[0] ? t1_ff : t0_ff, shut_ff[i / 2]);
            flag_x[i] <= h;
            pin_x[i] <= cfg_ff[3] && (cnt[i] != 11'h000);
            if (h) cnt[i] <= 11'h008 << cfg_ff[2:0];
            else if (cnt[i] != 11'h000) cnt[i] <= cnt[i] - 11'h001;
         end
      end
   end

   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   always @(negedge clk_i) begin
      if (arst_n_i) begin
         chk("flags", {8'h00, flag_x}, {8'h00, f_b1, f_b0, f_a1, f_a0});
         chk("pins", {8'h00, pin_x}, {8'h00, p_b1, p_b0, p_a1, p_a0});
         chk("shutdown", {10'h000, shut_ff[1:0]}, {10'h000, sh_b, sh_a});
         chk("lanes_a", {12{~shut_ff[0]}}, lanes_a);
         chk("lanes_b", {12{~shut_ff[1]}}, lanes_b);
         chk("strobe_clk", {8'h00, ~shut_ff[1:0], ~shut_ff[1:0]}, {8'h00, stb_en, clk_en});
         chk("auto_select", {11'h000, st_ff[0]}, {11'h000, auto_sel});
      end
   end

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rchk(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), {4'h0, e}, {4'h0, rdata_o});
   endtask : rchk

   task automatic put(input logic [11:0] a, input logic [11:0] b, input int n);
      repeat (n) begin
         @(posedge clk_i);
         sa <= a;
         sb <= b;
      end
   endtask : put

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 8000) begin
         err_total++;
         $display("FAIL timeout expected finish seen hang");
         stop_test();
      end
   end

   initial begin
      logic [11:0] ra [5];
      logic [7:0] rm [5];
      logic [11:0] cs [7];
      int lim, n;
      ra = '{12'h209, 12'h211, 12'h212, 12'h213, 12'h2b1};
      rm = '{8'h03, 8'hff, 8'hff, 8'h0f, 8'h0f};
      cs = '{12'h400, 12'h3ff, 12'hc00, 12'hc01, 12'h800, 12'h7ff, 12'h000};
      void'($urandom(17649));
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      // reset values, reserved and unmapped places
      rchk(orc_pkg::OFS_CHAN_SHUTDOWN, 8'h00);
      rchk(orc_pkg::OFS_LEVEL_ZERO, 8'hf2);
      rchk(orc_pkg::OFS_LEVEL_ONE, 8'hab);
      rchk(orc_pkg::OFS_OUTPUT_CONFIG, 8'h07);
      rchk(orc_pkg::OFS_CAL_START, 8'h00);
      rchk(orc_pkg::OFS_CAL_SETUP, 8'h05);
      rchk(orc_pkg::OFS_CAL_STAT_2, 8'h00);
      wr(orc_pkg::OFS_REVISION, 8'hff);
      rchk(orc_pkg::OFS_REVISION, {3'b000, REV});
      wr(12'h2c0, 8'hff);
      rchk(12'h2c0, 8'h00);
      for (int k = 0; k < 20; k++) begin
         int j;
         logic [7:0] d;
         j = $urandom % 5;
         d = 8'($urandom);
         // software never shuts both channels through the shutdown bits
         if (j == 0 && d[1:0] == 2'b11) d[1] = 1'b0;
         wr(ra[j], d);
         rchk(ra[j], d & rm[j]);
      end
      $display("test registers done");
      wr(orc_pkg::OFS_CHAN_SHUTDOWN, 8'h00);
      wr(orc_pkg::OFS_LEVEL_ZERO, 8'h80);
      wr(orc_pkg::OFS_LEVEL_ONE, 8'hff);
      wr(orc_pkg::OFS_OUTPUT_CONFIG, 8'h08);
      for (int k = 0; k < 7; k++) begin
         put(cs[k], cs[6 - k], 1);
         put(12'h000, 12'h000, 12);
      end
      put(12'h7ff, 12'h800, 1);
      put(12'h000, 12'h000, 5);
      put(12'h7ff, 12'h800, 1);
      put(12'h000, 12'h000, 14);
      wr(orc_pkg::OFS_OUTPUT_CONFIG, 8'h01);
      put(12'h800, 12'h800, 3);
      put(12'h000, 12'h000, 20);
      $display("test thresholds done");
      wr(orc_pkg::OFS_OUTPUT_CONFIG, 8'h0a);
      for (int k = 1; k < 4; k++) begin
         wr(orc_pkg::OFS_CHAN_SHUTDOWN, k == 3 ? 8'h00 : k[7:0]);
         put(12'h800, 12'h7ff, 4);
         put(12'h000, 12'h000, 40);
      end
      $display("test shutdown done");
      for (int r = 0; r < 6; r++) begin
         wr(orc_pkg::OFS_LEVEL_ZERO, r == 0 ? 8'h00 : 8'($urandom));
         wr(orc_pkg::OFS_LEVEL_ONE, 8'($urandom));
         wr(orc_pkg::OFS_OUTPUT_CONFIG, r == 0 ? 8'h0f : 8'($urandom) & 8'h0f);
         wr(orc_pkg::OFS_CHAN_SHUTDOWN, 8'($urandom % 3));
         repeat (150) put(($urandom % 8 == 0) ? 12'($urandom) : 12'($urandom) & 12'h0ff,
                          ($urandom % 8 == 0) ? 12'($urandom) : 12'($urandom) & 12'h0ff, 1);
      end
      $display("test random overrange done");
      for (int c = 0; c < 16; c++) begin
         wr(orc_pkg::OFS_CAL_SETUP, c[7:0]);
         wr(orc_pkg::OFS_CAL_START, 8'h01);
         lim = UNIT * (c / 4 + c % 4 + 2);
         n = 0;
         #1;
         while (done !== 1'b1 && n < lim + 4) begin
            @(posedge clk_i);
            #1;
            n++;
         end
         chk("cal_done", 12'h001, {11'h000, done});
         chk("cal_time", 12'h001, {11'h000, n >= lim && n <= lim + 2});
         rchk(orc_pkg::OFS_CAL_STAT_2, 8'h02);
         wr(orc_pkg::OFS_CAL_START, 8'h01);
         put(12'h000, 12'h000, 3);
         chk("steady_high", 12'h001, {10'h000, busy, done});
         wr(orc_pkg::OFS_CAL_START, 8'h00);
         put(12'h000, 12'h000, 2);
         chk("cal_clear", 12'h000, {10'h000, busy, done});
      end
      wr(orc_pkg::OFS_CAL_START, 8'h01);
      put(12'h000, 12'h000, 3);
      chk("cal_run", 12'h002, {10'h000, busy, done});
      wr(orc_pkg::OFS_CAL_START, 8'h00);
      put(12'h000, 12'h000, 2);
      chk("cal_abort", 12'h000, {10'h000, busy, done});
      rchk(orc_pkg::OFS_CAL_STAT_2, 8'h00);
      wr(orc_pkg::OFS_CAL_START, 8'h01);
      put(12'h000, 12'h000, 3);
      chk("cal_restart", 12'h002, {10'h000, busy, done});
      $display("test calibration done");
      stop_test();
   end
endmodule : testbench

// >>> src/orc_ovr_stretch.sv
// one overrange detector: magnitude compare and pulse stretcher
// assumes sample_i comes from logic on clk_i, two's complement
`timescale 1ns/10ps
module orc_ovr_stretch #(
   parameter int SAMPLE_W = orc_pkg::SAMPLE_W,
   parameter int CNT_W = orc_pkg::PULSE_CNT_W
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic [SAMPLE_W-1:0] sample_i,
   input wire logic active_i,
   input wire logic [orc_pkg::LEVEL_W-1:0] level_i,
   input wire logic [orc_pkg::PULSE_EXP_W-1:0] exponent_i,
   output logic flag_o,
   output logic pulse_o
);

   logic [SAMPLE_W-1:0] mag;
   logic [SAMPLE_W-1:0] limit;
   logic hit;
   logic [CNT_W-1:0] reload;
   logic [CNT_W-1:0] cnt_ff;
   logic pulse_ff;
   logic flag_ff;

   // level code sits on the top eight magnitude bits, full scale at 2^(SAMPLE_W-1)
   assign mag = sample_i[SAMPLE_W-1] ? SAMPLE_W'(-sample_i) : sample_i;
   assign limit = {1'b0, level_i, (SAMPLE_W - 1 - orc_pkg::LEVEL_W)'(0)};
   assign hit = active_i && (mag >= limit);
   assign reload = CNT_W'((orc_pkg::PULSE_BASE_CYCLES << exponent_i) - 1);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flag_ff <= 1'b0;
      end else if (ce_i) begin
         flag_ff <= hit;
      end
   end

   // every further crossing restarts the hold count
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_ff <= '0;
         pulse_ff <= 1'b0;
      end else if (ce_i) begin
         if (hit) begin
            cnt_ff <= reload;
            pulse_ff <= 1'b1;
         end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
         end else begin
            pulse_ff <= 1'b0;
         end
      end
   end

   assign flag_o = flag_ff;
   assign pulse_o = pulse_ff;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   a_hit_raises_pulse: assert property (ce_i && hit |=> pulse_ff && cnt_ff == $past(reload))
      else $error("crossing did not start a full pulse");
   a_pulse_holds_min: assert property (pulse_ff && cnt_ff != '0 |=> pulse_ff)
      else $error("pulse ended before hold count expired");
   a_flag_follows_hit: assert property (ce_i |=> flag_ff == $past(hit))
      else $error("level flag does not follow the crossing");

endmodule : orc_ovr_stretch

// >>> src/orc_regs.sv
// overrange detection and sysref calibration control registers
// assumes samples and register port are synchronous to clk_i
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps

// Functional notes
// - shutdown bit 0 powers down channel a; clear keeps it running.
// - a shut channel has its twelve lanes, frame strobe and clock disabled.
// - level-zero register, reset f2, sets level-zero flags when magnitude reaches it.
// - threshold code t means t/256 of full scale on top magnitude bits.
// - level-one register, reset ab, sets level-one flags when magnitude reaches it.
// - pins enable bit 3 shows overrange on four pins, else drives them low.
// - pulse exponent n, reset 7, holds each pin at least 8*2^n cycles.
// - read-only five-bit revision code, upper three bits reserved zero.
// - calibration enable low selects the manual aperture delay.
// - calibration enable high selects automatic aperture delay, ignoring manual value.
// - each rising edge of calibration enable starts one calibration run.
// - calibration finishes within 256*19*4*(avg+len+2) cycles.
// - averaging field bits 3-2, reset 1, picks 4/16/64/256 accumulations.
// - length field bits 1-0 picks 4/16/64/256 cycles per accumulation.
// - complete bit 17 reads one only while enabled and finished.
module orc_regs #(
   parameter int CAL_UNIT_CYCLES = orc_pkg::CAL_UNIT_CYCLES,
   // arbitrary neutral revision code
   parameter logic [orc_pkg::REV_W-1:0] REVISION_CODE = 5'h0a,
   parameter int SAMPLE_W = orc_pkg::SAMPLE_W,
   parameter int LANES = orc_pkg::LANES
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic [orc_pkg::ADDR_W-1:0] addr_i,
   input wire logic [orc_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [orc_pkg::DATA_W-1:0] rdata_o,
   input wire logic [SAMPLE_W-1:0] chan_a_sample_i,
   input wire logic [SAMPLE_W-1:0] chan_b_sample_i,
   output logic shutdown_chan_a_o,
   output logic shutdown_chan_b_o,
   output logic [LANES-1:0] chan_a_lanes_enable_o,
   output logic [LANES-1:0] chan_b_lanes_enable_o,
   output logic [1:0] lane_frame_strobe_enable_o,
   output logic [1:0] lane_output_clock_enable_o,
   output logic chan_a_level0_flag_o,
   output logic chan_a_level1_flag_o,
   output logic chan_b_level0_flag_o,
   output logic chan_b_level1_flag_o,
   output logic chan_a_level0_pin_o,
   output logic chan_a_level1_pin_o,
   output logic chan_b_level0_pin_o,
   output logic chan_b_level1_pin_o,
   output logic aperture_auto_select_o,
   output logic sysref_cal_busy_o,
   output logic sysref_cal_complete_o
);

   logic [orc_pkg::DATA_W-1:0] shutdown_ff;
   logic [orc_pkg::DATA_W-1:0] level_zero_ff;
   logic [orc_pkg::DATA_W-1:0] level_one_ff;
   logic [orc_pkg::DATA_W-1:0] out_cfg_ff;
   logic [orc_pkg::DATA_W-1:0] cal_start_ff;
   logic [orc_pkg::DATA_W-1:0] cal_setup_ff;
   logic [orc_pkg::DATA_W-1:0] rdata_ff;
   logic [orc_pkg::DATA_W-1:0] nxt_rdata;
   logic [3:0] pins_ff;
   logic [3:0] flags;
   logic [3:0] stretched;
   logic [SAMPLE_W-1:0] det_sample [4];
   logic [3:0] det_active;
   logic [orc_pkg::LEVEL_W-1:0] det_level [4];
   logic pins_en;
   logic cal_en;
   logic cal_en_prev_ff;
   logic cal_rise;
   logic cal_complete;
   orc_pkg::orc_cal_state_type cal_state_ff;
   logic [orc_pkg::CAL_CNT_W-1:0] cal_cnt_ff;
   logic [orc_pkg::CAL_CNT_W-1:0] cal_len;
   logic [orc_pkg::CAL_FIELD_W-1:0] cal_avg;
   logic [orc_pkg::CAL_FIELD_W-1:0] cal_acc;

   // ---------------- register writes
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         shutdown_ff <= orc_pkg::RST_CHAN_SHUTDOWN;
         level_zero_ff <= orc_pkg::RST_LEVEL_ZERO;
         level_one_ff <= orc_pkg::RST_LEVEL_ONE;
         out_cfg_ff <= orc_pkg::RST_OUTPUT_CONFIG;
         cal_start_ff <= orc_pkg::RST_CAL_START;
         cal_setup_ff <= orc_pkg::RST_CAL_SETUP;
      end else if (ce_i && wr_i) begin
         case (addr_i)
            orc_pkg::OFS_CHAN_SHUTDOWN: begin
               shutdown_ff <= wdata_i & orc_pkg::WMASK_CHAN_SHUTDOWN;
            end
            orc_pkg::OFS_LEVEL_ZERO: begin
               level_zero_ff <= wdata_i;
            end
            orc_pkg::OFS_LEVEL_ONE: begin
               level_one_ff <= wdata_i;
            end
            orc_pkg::OFS_OUTPUT_CONFIG: begin
               out_cfg_ff <= wdata_i & orc_pkg::WMASK_OUTPUT_CONFIG;
            end
            orc_pkg::OFS_CAL_START: begin
               cal_start_ff <= wdata_i & orc_pkg::WMASK_CAL_START;
            end
            orc_pkg::OFS_CAL_SETUP: begin
               cal_setup_ff <= wdata_i & orc_pkg::WMASK_CAL_SETUP;
            end
            default: begin
            end
         endcase
      end
   end

   // ---------------- register reads, data valid the cycle after the strobe
   always_comb begin
      nxt_rdata = '0;
      case (addr_i)
         orc_pkg::OFS_CHAN_SHUTDOWN: nxt_rdata = shutdown_ff;
         orc_pkg::OFS_LEVEL_ZERO: nxt_rdata = level_zero_ff;
         orc_pkg::OFS_LEVEL_ONE: nxt_rdata = level_one_ff;
         orc_pkg::OFS_OUTPUT_CONFIG: nxt_rdata = out_cfg_ff;
         orc_pkg::OFS_REVISION: nxt_rdata = {3'h0, REVISION_CODE};
         orc_pkg::OFS_CAL_START: nxt_rdata = cal_start_ff;
         orc_pkg::OFS_CAL_SETUP: nxt_rdata = cal_setup_ff;
         orc_pkg::OFS_CAL_STAT_2: nxt_rdata[orc_pkg::CAL_DONE_BIT] = cal_complete;
         default: nxt_rdata = '0;
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_ff <= '0;
      end else if (ce_i) begin
         rdata_ff <= rd_i ? nxt_rdata : '0;
      end
   end

   assign rdata_o = rdata_ff;

   // ---------------- channel shutdown and lane gating
   assign shutdown_chan_a_o = shutdown_ff[orc_pkg::SHUT_A_BIT];
   assign shutdown_chan_b_o = shutdown_ff[orc_pkg::SHUT_B_BIT];
   assign chan_a_lanes_enable_o = {LANES{~shutdown_chan_a_o}};
   assign chan_b_lanes_enable_o = {LANES{~shutdown_chan_b_o}};
   assign lane_frame_strobe_enable_o = {~shutdown_chan_b_o, ~shutdown_chan_a_o};
   assign lane_output_clock_enable_o = {~shutdown_chan_b_o, ~shutdown_chan_a_o};

   // ---------------- overrange detectors: index 0 a/l0, 1 a/l1, 2 b/l0, 3 b/l1
   assign pins_en = out_cfg_ff[orc_pkg::PINS_EN_BIT];

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_det
         assign det_sample[gi] = (gi < 2) ? chan_a_sample_i : chan_b_sample_i;
         assign det_active[gi] = (gi < 2) ? ~shutdown_chan_a_o : ~shutdown_chan_b_o;
         assign det_level[gi] = (gi % 2 == 0) ? level_zero_ff : level_one_ff;
         orc_ovr_stretch #(
            .SAMPLE_W(SAMPLE_W),
            .CNT_W(orc_pkg::PULSE_CNT_W)
         ) u_det (
            .clk_i(clk_i),
            .arst_n_i(arst_n_i),
            .ce_i(ce_i),
            .sample_i(det_sample[gi]),
            .active_i(det_active[gi]),
            .level_i(det_level[gi]),
            .exponent_i(out_cfg_ff[orc_pkg::PULSE_EXP_LSB +: orc_pkg::PULSE_EXP_W]),
            .flag_o(flags[gi]),
            .pulse_o(stretched[gi])
         );
      end
   endgenerate

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pins_ff <= '0;
      end else if (ce_i) begin
         pins_ff <= pins_en ? stretched : 4'h0;
      end
   end

   assign chan_a_level0_flag_o = flags[0];
   assign chan_a_level1_flag_o = flags[1];
   assign chan_b_level0_flag_o = flags[2];
   assign chan_b_level1_flag_o = flags[3];
   assign chan_a_level0_pin_o = pins_ff[0];
   assign chan_a_level1_pin_o = pins_ff[1];
   assign chan_b_level0_pin_o = pins_ff[2];
   assign chan_b_level1_pin_o = pins_ff[3];

   // ---------------- sysref calibration sequencer
   assign cal_en = cal_start_ff[orc_pkg::CAL_START_BIT];
   assign aperture_auto_select_o = cal_en;
   assign cal_avg = cal_setup_ff[orc_pkg::CAL_AVG_LSB +: orc_pkg::CAL_FIELD_W];
   assign cal_acc = cal_setup_ff[orc_pkg::CAL_ACC_LSB +: orc_pkg::CAL_FIELD_W];
   assign cal_len = orc_pkg::CAL_CNT_W'(CAL_UNIT_CYCLES * (int'(cal_avg) + int'(cal_acc)
                    + orc_pkg::CAL_CODE_BIAS));

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cal_en_prev_ff <= 1'b0;
      end else if (ce_i) begin
         cal_en_prev_ff <= cal_en;
      end
   end

   // only a 0-to-1 change starts a run, a steady high does not
   assign cal_rise = cal_en && !cal_en_prev_ff;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cal_state_ff <= orc_pkg::CAL_IDLE;
         cal_cnt_ff <= '0;
      end else if (ce_i) begin
         case (cal_state_ff)
            orc_pkg::CAL_IDLE: begin
               if (cal_rise) begin
                  cal_state_ff <= orc_pkg::CAL_RUN;
                  cal_cnt_ff <= cal_len - 1'b1;
               end
            end
            orc_pkg::CAL_RUN: begin
               if (!cal_en) begin
                  cal_state_ff <= orc_pkg::CAL_IDLE;
               end else if (cal_cnt_ff == '0) begin
                  cal_state_ff <= orc_pkg::CAL_FINISHED;
               end else begin
                  cal_cnt_ff <= cal_cnt_ff - 1'b1;
               end
            end
            orc_pkg::CAL_FINISHED: begin
               if (!cal_en) begin
                  cal_state_ff <= orc_pkg::CAL_IDLE;
               end
            end
            default: begin
               cal_state_ff <= orc_pkg::CAL_IDLE;
            end
         endcase
      end
   end

   assign cal_complete = cal_en && (cal_state_ff == orc_pkg::CAL_FINISHED);
   assign sysref_cal_complete_o = cal_complete;
   assign sysref_cal_busy_o = (cal_state_ff == orc_pkg::CAL_RUN);

   // ---------------- checks
   logic [orc_pkg::CAL_CNT_W-1:0] run_age_ff;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         run_age_ff <= '0;
      end else if (ce_i) begin
         run_age_ff <= sysref_cal_busy_o ? run_age_ff + 1'b1 : '0;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   a_shut_lane_gate: assert property (chan_a_lanes_enable_o[0] != shutdown_ff[0]
      && lane_output_clock_enable_o[1] != shutdown_ff[1])
      else $error("lane enables disagree with channel shutdown");
   a_shut_write_a: assert property (ce_i && wr_i && addr_i == orc_pkg::OFS_CHAN_SHUTDOWN
      |=> shutdown_chan_a_o == $past(wdata_i[0]))
      else $error("channel a shutdown not taken from write");
   a_pins_held_low: assert property (ce_i && !pins_en |=> pins_ff == 4'h0)
      else $error("overrange pins not low while disabled");
   a_pins_follow: assert property (ce_i && pins_en |=> pins_ff == $past(stretched))
      else $error("overrange pins do not follow status");
   a_rev_readback: assert property (ce_i && rd_i && addr_i == orc_pkg::OFS_REVISION
      |=> rdata_o == {3'h0, REVISION_CODE})
      else $error("revision read returned wrong code");
   a_cal_rise_starts: assert property (ce_i && cal_rise && cal_state_ff == orc_pkg::CAL_IDLE
      |=> sysref_cal_busy_o)
      else $error("rising enable did not start calibration");
   a_cal_no_rerun: assert property (cal_state_ff == orc_pkg::CAL_FINISHED && cal_en
      |=> cal_state_ff == orc_pkg::CAL_FINISHED)
      else $error("steady enable restarted calibration");
   a_cal_bounded: assert property (run_age_ff <= cal_len)
      else $error("calibration ran past its limit");
   a_cal_complete: assert property (sysref_cal_complete_o |-> cal_en
      && !sysref_cal_busy_o)
      else $error("complete bit set without finished enabled run");
   a_aperture_sel: assert property (ce_i && wr_i && addr_i == orc_pkg::OFS_CAL_START
      |=> aperture_auto_select_o == $past(wdata_i[0]))
      else $error("aperture source not following enable");

   c_cal_done: cover property (sysref_cal_busy_o ##1 sysref_cal_complete_o);
   c_pin_pulse: cover property (pins_en && $rose(chan_a_level0_pin_o));
   c_chan_b_shut: cover property ($rose(shutdown_chan_b_o));
   c_cal_abort: cover property (sysref_cal_busy_o && !cal_en);

endmodule : orc_regs
